// [rtl/pace_pkg.sv]
// What this block does
// RULE1: Slope limit register is signed 8-bit
// RULE2: Leading edge ends when interval change meets limit
// RULE3: Slope limit counts in sample LSBs, -128..127
// RULE4: Always reject leading edge beyond about 156 us
// RULE5: Reject candidates below unsigned height minimum
// RULE6: Height threshold is twice the programmed count
// RULE7: Software keeps height above edge trigger
// RULE8: Height minimum resets to 0x24
// RULE9: Software avoids heights below 250 uV
// RULE10: Two optional shape filters follow amplitude test
// RULE11: Control bits 9 and 10 enable filters, set
// RULE12: Filter enables apply to every lead jointly
// RULE13: Bit 11 enables 100 us to 2 ms window
// RULE14: Maximum width check never disabled
// RULE15: Passing candidate stores its measured width
// RULE16: Merged pulses within 2 ms flag once
// RULE17: Zero edge trigger means half the height
// RULE18: Valid pace sets flag and result register
// RULE19: Works on the 128 kHz sample stream
// RULE20: Polarity taken from leading edge slope
// RULE21: Thresholds writable anytime, read back, used next
package pace_pkg;
  localparam int REG_W = 16;
  localparam logic [7:0] OFF_CONTROL    = 8'h04;
  localparam logic [7:0] OFF_HEIGHT_MIN = 8'h07;
  localparam logic [7:0] OFF_EDGE_TRIG  = 8'h0E;
  localparam logic [7:0] OFF_SLOPE_LIM  = 8'h0F;
  localparam logic [7:0] OFF_RESULT     = 8'h1A;
  localparam logic [7:0]  RST_HEIGHT_MIN = 8'h24;
  localparam logic [7:0]  RST_EDGE_TRIG  = 8'h00;
  localparam logic [7:0]  RST_SLOPE_LIM  = 8'h00;
  localparam logic [15:0] RST_CONTROL    = 16'h0E00;
  localparam int CTL_FILT1_BIT = 9;
  localparam int CTL_FILT2_BIT = 10;
  localparam int CTL_WIDTH_BIT = 11;
  localparam int CTL_SEEN_BIT  = 15;
  localparam int RES_HEIGHT_LSB = 9;
  localparam longint SAMPLE_RATE_HZ = 128000;
  localparam longint NS_PER_S       = 1000000000;
  localparam longint RISE_MAX_NS    = 156000;
  localparam longint WIDTH_MIN_NS   = 100000;
  localparam longint WIDTH_MAX_NS   = 2000000;
  localparam int RISE_MAX_SMP  = int'((RISE_MAX_NS * SAMPLE_RATE_HZ) / NS_PER_S);
  localparam int WIDTH_MIN_SMP = int'((WIDTH_MIN_NS * SAMPLE_RATE_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int WIDTH_MAX_SMP = int'((WIDTH_MAX_NS * SAMPLE_RATE_HZ) / NS_PER_S);
  localparam int SLOPE_IVL_SMP = 2;
  localparam int BASE_SHIFT    = 4;

  typedef enum logic [1:0] {st_idle, st_slope, st_top} qual_state_t;

  // Difference a-b, turned so that motion away from baseline is positive
  function automatic logic signed [16:0] pol_diff(input logic neg,
                                                   input logic signed [15:0] a,
                                                   input logic signed [15:0] b);
    logic signed [16:0] d;
    d = {a[15], a} - {b[15], b};
    return neg ? -d : d;
  endfunction
endpackage

// [rtl/pace_pulse_qualifier.sv]
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pace_pulse_qualifier
  import pace_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_smp_valid,
  input  wire logic [15:0]       i_smp,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [REG_W-1:0]  i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output var  logic [REG_W-1:0]  o_reg_rdata,
  output var  logic              o_pace_flag,
  output var  logic [8:0]        o_pace_width,
  output var  logic [7:0]        o_pace_height
);
  typedef struct packed {
    qual_state_t        st;
    logic [7:0]         height_min;
    logic [7:0]         edge_trig;
    logic [7:0]         slope_lim;
    logic [15:0]        control;
    logic               seen;
    logic signed [15:0] base;
    logic signed [15:0] anchor;
    logic               neg;
    logic [4:0]         rise_cnt;
    logic [1:0]         ivl_cnt;
    logic signed [16:0] peak;
    logic               start;
    logic [15:0]        result;
    logic [REG_W-1:0]   rdata;
    logic               flag;
    logic [8:0]         width;
    logic [7:0]         height;
  } qual_t;

  qual_t        st_reg;
  qual_t        st_next;
  logic         rej1;
  logic         rej2;
  pace_shape_if sif ();

  pace_width_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (sif)
  );

  pace_shape_check #(.STEP_MODE(1'b0)) u_filt1 (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (sif),
    .o_reject  (rej1)
  );

  pace_shape_check #(.STEP_MODE(1'b1)) u_filt2 (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (sif),
    .o_reject  (rej2)
  );

  assign sif.smp_stb = i_smp_valid;
  assign sif.start   = st_reg.start;
  assign sif.active  = (st_reg.st == st_top);
  assign sif.dev     = pol_diff(st_reg.neg, i_smp, st_reg.base);
  assign sif.half    = st_reg.peak >>> 1;

  always_comb
  begin
    logic signed [16:0] d;
    logic signed [16:0] mag;
    logic signed [16:0] ch;
    logic signed [16:0] edge_th;
    logic signed [16:0] amp_th;
    logic signed [16:0] slope_th;
    logic               keep;
    d        = pol_diff(1'b0, i_smp, st_reg.base);
    mag      = (d < 0) ? -d : d;
    ch       = pol_diff(st_reg.neg, i_smp, st_reg.anchor);
    edge_th  = (st_reg.edge_trig != 8'h00) ? {9'h000, st_reg.edge_trig}
                                           : {9'h000, st_reg.height_min}; // RULE17
    amp_th   = {8'h00, st_reg.height_min, 1'b0}; // RULE6
    slope_th = {{9{st_reg.slope_lim[7]}}, st_reg.slope_lim}; // RULE1 RULE3
    keep     = 1'b0;
    st_next       = st_reg;
    st_next.flag  = 1'b0;
    st_next.start = 1'b0;
    st_next.rdata = '0;

    if (i_reg_wr)
    begin
      // New thresholds apply to the next sample compared; a candidate in flight mixes both
      if (i_reg_addr == OFF_HEIGHT_MIN)
        st_next.height_min = i_reg_wdata[7:0]; // RULE21
      else if (i_reg_addr == OFF_EDGE_TRIG)
        st_next.edge_trig = i_reg_wdata[7:0];
      else if (i_reg_addr == OFF_SLOPE_LIM)
        st_next.slope_lim = i_reg_wdata[7:0];
      else if (i_reg_addr == OFF_CONTROL)
        st_next.control = {1'b0, i_reg_wdata[14:0]};
    end

    if (i_reg_rd)
    begin
      if (i_reg_addr == OFF_HEIGHT_MIN)
        st_next.rdata = {8'h00, st_reg.height_min}; // RULE21
      else if (i_reg_addr == OFF_EDGE_TRIG)
        st_next.rdata = {8'h00, st_reg.edge_trig};
      else if (i_reg_addr == OFF_SLOPE_LIM)
        st_next.rdata = {8'h00, st_reg.slope_lim};
      else if (i_reg_addr == OFF_CONTROL)
        st_next.rdata = {st_reg.seen, st_reg.control[14:0]};
      else if (i_reg_addr == OFF_RESULT)
      begin
        st_next.rdata = st_reg.result;
        st_next.seen  = 1'b0;
      end
    end

    if (i_smp_valid) // RULE19
    begin
      case (st_reg.st)
        st_idle:
        begin
          if (mag >= edge_th && mag != 0)
          begin
            st_next.neg      = d[16]; // RULE20
            st_next.anchor   = i_smp;
            st_next.rise_cnt = 5'd1;
            st_next.ivl_cnt  = 2'd0;
            st_next.start    = 1'b1;
            st_next.st       = st_slope;
          end
          else
            // Slow baseline so a leading edge spread over samples is still seen
            st_next.base = st_reg.base + 16'(d >>> BASE_SHIFT);
        end
        st_slope:
        begin
          st_next.rise_cnt = st_reg.rise_cnt + 5'd1;
          st_next.ivl_cnt  = st_reg.ivl_cnt + 2'd1;
          if (int'(st_reg.rise_cnt) > RISE_MAX_SMP)
            st_next.st = st_idle; // RULE4
          else if (int'(st_reg.ivl_cnt) == SLOPE_IVL_SMP - 1)
          begin
            st_next.ivl_cnt = 2'd0;
            st_next.anchor  = i_smp;
            if (ch <= slope_th) // RULE2
            begin
              if (sif.dev >= amp_th) // RULE5
              begin
                st_next.peak = sif.dev;
                st_next.st   = st_top;
              end
              else
                st_next.st = st_idle;
            end
          end
        end
        st_top:
        begin
          if (sif.dev > st_reg.peak)
            st_next.peak = sif.dev;
          if (int'(sif.count) > WIDTH_MAX_SMP)
            st_next.st = st_idle; // RULE14
          else if (sif.dev < sif.half)
          begin
            st_next.st = st_idle;
            keep = 1'b1;
            // One enable pair serves every lead this qualifier watches
            if (st_reg.control[CTL_FILT1_BIT] && rej1)
              keep = 1'b0; // RULE10 RULE11 RULE12
            if (st_reg.control[CTL_FILT2_BIT] && rej2)
              keep = 1'b0; // RULE10 RULE11 RULE12
            if (st_reg.control[CTL_WIDTH_BIT] && int'(sif.count) < WIDTH_MIN_SMP)
              keep = 1'b0; // RULE13
            // Merged twin pulses pass as one while inside the maximum
            if (keep) // RULE16
            begin
              st_next.flag   = 1'b1; // RULE18
              st_next.seen   = 1'b1;
              st_next.width  = sif.count; // RULE15
              st_next.height = (st_reg.peak[16:9] != 8'h00) ? 8'hFF
                                                           : st_reg.peak[8:1];
              st_next.result = {st_next.height[7:1], sif.count}; // RULE18
            end
          end
        end
        default:
          st_next.st = st_idle;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_reg            <= '0;
      st_reg.st         <= st_idle;
      st_reg.height_min <= RST_HEIGHT_MIN; // RULE8
      st_reg.edge_trig  <= RST_EDGE_TRIG;
      st_reg.slope_lim  <= RST_SLOPE_LIM;
      st_reg.control    <= RST_CONTROL; // RULE11
    end
    else
      st_reg <= st_next;
  end

  assign o_reg_rdata   = st_reg.rdata;
  assign o_pace_flag   = st_reg.flag;
  assign o_pace_width  = st_reg.width;
  assign o_pace_height = st_reg.height;

  property p_height_reset;
    @(posedge i_sys_clk) $fell(i_rst) |-> st_reg.height_min == RST_HEIGHT_MIN;
  endproperty
  a_height_reset: assert property (p_height_reset) // RULE8
    else $error("height minimum wrong after reset");

  property p_filters_reset;
    @(posedge i_sys_clk) $fell(i_rst) |->
      st_reg.control[CTL_FILT1_BIT] && st_reg.control[CTL_FILT2_BIT];
  endproperty
  a_filters_reset: assert property (p_filters_reset) // RULE11
    else $error("filter enables not set after reset");

  property p_readback;
    @(posedge i_sys_clk) disable iff (i_rst)
      i_reg_rd && i_reg_addr == OFF_SLOPE_LIM |=>
      o_reg_rdata == {8'h00, $past(st_reg.slope_lim)};
  endproperty
  a_readback: assert property (p_readback) // RULE21
    else $error("slope limit read back wrong");

  property p_rdata_idle;
    @(posedge i_sys_clk) disable iff (i_rst)
      !i_reg_rd |=> o_reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RULE21
    else $error("read data not cleared after read");

  property p_flag_pulse;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_pace_flag |-> st_reg.seen && o_pace_width == st_reg.result[8:0] ##1 !o_pace_flag;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) // RULE18
    else $error("pace flag or result inconsistent");

  property p_width_max;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_pace_flag |-> int'(o_pace_width) <= WIDTH_MAX_SMP;
  endproperty
  a_width_max: assert property (p_width_max) // RULE14
    else $error("pace wider than maximum flagged");

  property p_width_min;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_pace_flag && $past(st_reg.control[CTL_WIDTH_BIT]) |->
      int'(o_pace_width) >= WIDTH_MIN_SMP;
  endproperty
  a_width_min: assert property (p_width_min) // RULE13
    else $error("narrow pace flagged with width filter on");

  property p_filt1_veto;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_pace_flag |-> !($past(rej1) && $past(st_reg.control[CTL_FILT1_BIT]));
  endproperty
  a_filt1_veto: assert property (p_filt1_veto) // RULE10
    else $error("pace flagged despite filter one reject");

  property p_rise_bound;
    @(posedge i_sys_clk) disable iff (i_rst)
      st_reg.st == st_top && $past(st_reg.st) == st_slope |->
      int'($past(st_reg.rise_cnt)) <= RISE_MAX_SMP;
  endproperty
  a_rise_bound: assert property (p_rise_bound) // RULE4
    else $error("slow leading edge accepted");

  property p_amp;
    @(posedge i_sys_clk) disable iff (i_rst)
      st_reg.st == st_top && $past(st_reg.st) == st_slope |->
      st_reg.peak >= $signed({8'h00, $past(st_reg.height_min), 1'b0});
  endproperty
  a_amp: assert property (p_amp) // RULE5
    else $error("candidate below height minimum accepted");
endmodule // pace_pulse_qualifier
`default_nettype wire

// [rtl/pace_shape_check.sv]
`timescale 1ns/100ps
`default_nettype none
module pace_shape_check
  import pace_pkg::*;
#(
  parameter bit STEP_MODE = 1'b0
)(
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst,
  pace_shape_if.shape bus,
  output var logic    o_reject
);
  typedef struct packed {
    logic               reject;
    logic signed [16:0] prev;
  } shape_t;
  shape_t st_reg;
  shape_t st_next;

  always_comb
  begin
    logic signed [16:0] step;
    step = '0;
    st_next = st_reg;
    if (bus.start)
      st_next.reject = 1'b0;
    else if (bus.smp_stb)
    begin
      step = bus.dev - st_reg.prev;
      if (step < 0)
        step = -step;
      st_next.prev = bus.dev;
      if (bus.active)
      begin
        // Top crossing baseline looks biphasic; large steps look like telemetry
        if (!STEP_MODE && bus.dev < 0)
          st_next.reject = 1'b1;
        if (STEP_MODE && step > bus.half)
          st_next.reject = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // A baseline crossing on the top is also the trailing sample, so filter one
  // judges the sample in hand; a registered flag alone would come too late
  assign o_reject = st_reg.reject
                    || (!STEP_MODE && bus.active && bus.smp_stb && bus.dev < 0);
endmodule // pace_shape_check
`default_nettype wire

// [rtl/pace_shape_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface pace_shape_if;
  logic               smp_stb;
  logic               start;
  logic               active;
  logic signed [16:0] dev;
  logic signed [16:0] half;
  logic [8:0]         count;
  modport qual  (output smp_stb, start, active, dev, half, input count);
  modport shape (input smp_stb, start, active, dev, half);
  modport timer (input smp_stb, start, output count);
endinterface // pace_shape_if
`default_nettype wire

// [rtl/pace_width_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module pace_width_timer
  import pace_pkg::*;
(
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst,
  pace_shape_if.timer bus
);
  typedef struct packed {
    logic [8:0] count;
  } timer_t;
  timer_t st_reg;
  timer_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (bus.start)
      // Trigger sample is the first of the width; a sample in the start cycle the second
      st_next.count = bus.smp_stb ? 9'h002 : 9'h001;
    // Saturates so an endless top can never wrap back into range
    else if (bus.smp_stb && st_reg.count != 9'h1FF)
      st_next.count = st_reg.count + 9'h001;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bus.count = st_reg.count;
endmodule // pace_width_timer
`default_nettype wire

// [test/ecg_sample_source.sv]
`timescale 1ns/100ps
`default_nettype none
module ecg_sample_source
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire logic [15:0] i_amp,
  input  wire logic [8:0]  i_len,
  input  wire logic [15:0] i_mid,
  input  wire logic [15:0] i_tail,
  output var  logic        o_busy,
  output var  logic        o_smp_valid,
  output var  logic [15:0] o_smp
);
  int unsigned idx;
  logic [1:0]  div;

  // Forty quiet samples first, so the tracked baseline has settled at zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_busy      <= 1'b0;
      o_smp_valid <= 1'b0;
      o_smp       <= 16'h0000;
      idx         <= 0;
      div         <= 2'h0;
    end
    else
    begin
      o_smp_valid <= 1'b0;
      // Between samples the bus holds no value, so it toggles every cycle
      o_smp       <= ~o_smp;
      if (i_go && !o_busy)
      begin
        o_busy <= 1'b1;
        idx    <= 0;
        div    <= 2'h0;
      end
      else if (o_busy)
      begin
        div <= div + 2'h1;
        if (div == 2'h3)
        begin
          o_smp_valid <= 1'b1;
          // Optional spike five samples in and optional trailing value shape the top
          if (idx == 40 + i_len)
            o_smp <= i_tail;
          else if (idx == 45 && i_mid != 16'h0000)
            o_smp <= i_mid;
          else
            o_smp <= (idx >= 40 && idx < 40 + i_len) ? i_amp : 16'h0000;
          idx         <= idx + 1;
          if (idx == 40 + i_len + 7)
            o_busy <= 1'b0;
        end
      end
    end
  end
endmodule // ecg_sample_source
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pace_pkg::*;
  logic              i_sys_clk;
  logic              i_rst;
  logic              smp_valid;
  logic [15:0]       smp;
  logic [7:0]        i_reg_addr;
  logic [REG_W-1:0]  i_reg_wdata;
  logic              i_reg_wr;
  logic              i_reg_rd;
  logic [REG_W-1:0]  o_reg_rdata;
  logic              o_pace_flag;
  logic [8:0]        o_pace_width;
  logic [7:0]        o_pace_height;
  logic              go;
  logic              busy;
  logic [15:0]       amp;
  logic [8:0]        len;
  logic [15:0]       mid;
  logic [15:0]       tail;
  logic [15:0]       d;
  int                fails;
  int                cmp_count;
  int                flag_cnt;

  pace_pulse_qualifier uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_smp_valid(smp_valid),
    .i_smp(smp), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_pace_flag(o_pace_flag),
    .o_pace_width(o_pace_width), .o_pace_height(o_pace_height));

  ecg_sample_source src (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_go(go), .i_amp(amp),
    .i_len(len), .i_mid(mid), .i_tail(tail), .o_busy(busy), .o_smp_valid(smp_valid),
    .o_smp(smp));

  always #2.5 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk)
    if (o_pace_flag === 1'b1)
      flag_cnt++;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= v;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 v = o_reg_rdata;
  endtask

  // Flat pulse; width is counted from trigger sample to trailing sample
  task automatic pulse(input logic [15:0] a, input logic [8:0] n, input logic exp_flag);
    int          k;
    int          f0;
    logic [15:0] mag;
    f0  = flag_cnt;
    mag = a[15] ? -a : a;
    if (mid > mag)
      mag = mid;
    @(posedge i_sys_clk);
    amp <= a;
    len <= n;
    go  <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    // Busy rises on the edge just passed; poll only once it shows
    @(posedge i_sys_clk);
    k = 0;
    while (busy !== 1'b0 && k < 5000)
    begin
      @(posedge i_sys_clk);
      k++;
    end
    if (k == 5000)
    begin
      fails++;
      $display("unexpected sample source timeout");
      stop_test();
    end
    check("pace count", 16'(flag_cnt - f0), {15'h0000, exp_flag});
    if (exp_flag)
    begin
      check("pace width", {7'h00, o_pace_width}, {7'h00, n});
      check("pace height", {8'h00, o_pace_height}, {8'h00, mag[8:1]});
    end
  endtask

  task automatic sc_reset_values();
    reg_read(OFF_HEIGHT_MIN, d);
    check("height min", d, 16'h0024);
    reg_read(OFF_CONTROL, d);
    check("control", d, 16'h0E00);
    reg_read(OFF_SLOPE_LIM, d);
    check("slope limit", d, 16'h0000);
    reg_read(OFF_EDGE_TRIG, d);
    check("edge trigger", d, 16'h0000);
    check("flag idle", {15'h0000, o_pace_flag}, 16'h0000);
  endtask

  task automatic sc_reg_access();
    reg_write(OFF_SLOPE_LIM, 16'h00FE);
    reg_read(OFF_SLOPE_LIM, d);
    check("slope readback", d, 16'h00FE);
    reg_write(8'h30, 16'hBEEF);
    reg_read(8'h30, d);
    check("unmapped", d, 16'h0000);
    reg_write(OFF_CONTROL, 16'h8000);
    reg_read(OFF_CONTROL, d);
    check("control write", d, 16'h0000);
    reg_write(OFF_CONTROL, 16'h0E00);
    reg_write(OFF_SLOPE_LIM, 16'h0000);
  endtask

  task automatic sc_valid_pace();
    pulse(16'd100, 9'd20, 1'b1);
    reg_read(OFF_CONTROL, d);
    check("pace seen", d, 16'h8E00);
    reg_read(OFF_RESULT, d);
    check("result", d, 16'h3214);
    reg_read(OFF_CONTROL, d);
    check("seen cleared", d, 16'h0E00);
    pulse(-16'sd100, 9'd20, 1'b1);
  endtask

  // Threshold is twice the count: 16 gives 32, still above the edge trigger
  task automatic sc_height();
    pulse(16'd60, 9'd20, 1'b0);
    reg_write(OFF_HEIGHT_MIN, 16'h0010);
    pulse(16'd31, 9'd20, 1'b0);
    pulse(16'd32, 9'd20, 1'b1);
    reg_write(OFF_HEIGHT_MIN, 16'h0024);
  endtask

  task automatic sc_slope();
    reg_write(OFF_SLOPE_LIM, 16'h0080);
    pulse(16'd100, 9'd30, 1'b0);
    reg_write(OFF_SLOPE_LIM, 16'h007F);
    pulse(16'd100, 9'd30, 1'b1);
    reg_write(OFF_SLOPE_LIM, 16'h0000);
  endtask

  task automatic sc_width();
    pulse(16'd100, 9'd12, 1'b0);
    pulse(16'd100, 9'd13, 1'b1);
    pulse(16'd100, 9'd256, 1'b1);
    pulse(16'd100, 9'd257, 1'b0);
    reg_write(OFF_CONTROL, 16'h0600);
    pulse(16'd100, 9'd12, 1'b1);
    pulse(16'd100, 9'd257, 1'b0);
    reg_write(OFF_CONTROL, 16'h0E00);
  endtask

  // Trailing sample below baseline trips filter one; a spike on the top trips filter two
  task automatic sc_filters();
    tail <= 16'hFFEC;
    pulse(16'd100, 9'd20, 1'b0);
    reg_write(OFF_CONTROL, 16'h0C00);
    pulse(16'd100, 9'd20, 1'b1);
    tail <= 16'h0000;
    mid  <= 16'd200;
    reg_write(OFF_CONTROL, 16'h0E00);
    pulse(16'd100, 9'd20, 1'b0);
    reg_write(OFF_CONTROL, 16'h0A00);
    pulse(16'd100, 9'd20, 1'b1);
    mid <= 16'h0000;
    reg_write(OFF_CONTROL, 16'h0E00);
  endtask

  initial
  begin
    i_sys_clk   = 1'b0;
    i_rst       = 1'b1;
    i_reg_addr  = 8'h00;
    i_reg_wdata = 16'h0000;
    i_reg_wr    = 1'b0;
    i_reg_rd    = 1'b0;
    go          = 1'b0;
    amp         = 16'h0000;
    len         = 9'h000;
    mid         = 16'h0000;
    tail        = 16'h0000;
    fails       = 0;
    cmp_count   = 0;
    flag_cnt    = 0;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    sc_reset_values();
    sc_reg_access();
    sc_valid_pace();
    sc_height();
    sc_slope();
    sc_width();
    sc_filters();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
